/* hw/robank_pkg.sv */
// Purpose: Constants for the remote object register bank
// Assumes: 125 MHz system clock, 7-bit objects, 4-bit object address
// Notes:   Object offsets are the printed object addresses
package robank_pkg;
	localparam int          CLK_HZ           = 125_000_000;
	localparam int          UNLOCK_HOLD_MS   = 2000;
	localparam int          UNLOCK_CYCLES    = (CLK_HZ / 1000) * UNLOCK_HOLD_MS;
	localparam int          OBJ_W            = 7;
	localparam logic [3:0]  OFS_STATUS       = 4'h0;
	localparam logic [3:0]  OFS_DUAL_SW      = 4'h1;
	localparam logic [3:0]  OFS_ATTEN_A      = 4'h2;
	localparam logic [3:0]  OFS_CHAN_A_SW    = 4'h3;
	localparam logic [3:0]  OFS_ATTEN_B      = 4'h4;
	localparam logic [3:0]  OFS_CHAN_B_SW    = 4'h5;
	localparam logic [3:0]  OFS_DLY_COARSE_A = 4'h6;
	localparam logic [3:0]  OFS_DLY_FINE_A   = 4'h7;
	localparam logic [3:0]  OFS_ERRORS       = 4'h8;
	localparam logic [3:0]  OFS_DLY_COARSE_B = 4'h9;
	localparam logic [3:0]  OFS_OUT_PILOT    = 4'hA;
	localparam logic [3:0]  OFS_DLY_FINE_B   = 4'hB;
	localparam logic [3:0]  OFS_IND_A        = 4'hC;
	localparam logic [3:0]  OFS_HEADROOM_A   = 4'hD;
	localparam logic [3:0]  OFS_IND_B        = 4'hE;
	localparam logic [3:0]  OFS_HEADROOM_B   = 4'hF;
	// Status object fields
	localparam int          ST_POWER_ON      = 0;
	localparam int          ST_POWER_GOOD    = 1;
	localparam int          ST_LOCK_ACTIVE   = 2;
	localparam int          ST_LOCK_CMD      = 3;
	localparam int          ST_REMOTE_SW     = 4;
	localparam int          ST_GEN_ERROR     = 5;
	localparam logic [6:0]  ST_WR_MASK       = 7'h09;
	localparam logic [6:0]  CHAN_SW_MASK     = 7'h6F;
	localparam logic [6:0]  IND_MASK         = 7'h77;
	localparam logic [6:0]  ERR_MASK         = 7'h35;
	localparam logic [6:0]  PILOT_RD_MASK    = 7'h01;
	localparam logic [6:0]  PILOT_WR_MASK    = 7'h7C;
	localparam logic [6:0]  COARSE_MAX       = 7'h16;
	localparam logic [6:0]  FINE_MAX         = 7'h7F;
	localparam logic [6:0]  ATTEN_RESET      = 7'h00;
	localparam logic [6:0]  OBJ_RESET        = 7'h00;
	localparam logic [1:0]  MODE_SIMPLE      = 2'h0;
	localparam logic [1:0]  MODE_SWITCHING   = 2'h1;
	localparam logic [1:0]  MODE_FULL        = 2'h2;
	typedef enum logic [1:0] {
		ROBANK_BOOT   = 2'b00,
		ROBANK_RUN    = 2'b01,
		ROBANK_RESET  = 2'b11,
		ROBANK_HALT   = 2'b10
	} robank_state_t;
endpackage : robank_pkg

/* hw/robank_top.sv */
// Purpose: Remote object register bank of an amplifier controller, first channel only
// Assumes: One clock, synchronous active-low reset acting as power-on reset
// Notes:   Objects of the second channel read as zero and ignore writes
//
// Function
// - Serve common and first-channel objects only
// - Attenuation: 7-bit half-decibel code
// - Coarse delay 10 ms steps, max 22
// - Unlock after two-second continuous encoder hold
// - Standby and password indications, not errors
// - Button held at power-up gives factory reset
// - Reset keeps node identifier only if saved
// - After factory reset, halt until power cycle
// - Simple mode: 18-28 V input switches on
// - Simple mode: fault output on any error flag inside ERR_MASK
// - Switching mode: bridge power loss forces standby
// - Full mode: bridge power loss keeps state
// - Both connectors logically identical, paralleled
// - Run start input unused; lock applies on the status write that commands it
`timescale 1ns/1ps
`default_nettype none
module robank_top
	import robank_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       obj_wr,
	input  wire logic       obj_rd,
	input  wire logic [3:0] obj_addr,
	input  wire logic [6:0] obj_wdata,
	output logic      [6:0] obj_rdata,
	input  wire logic       run_start,
	input  wire logic [1:0] remote_mode,
	input  wire logic       ctrl_voltage_ok_a,
	input  wire logic       ctrl_voltage_ok_b,
	input  wire logic       bridge_power_ok,
	input  wire logic       encoder_pressed,
	input  wire logic       mute_power_button,
	input  wire logic       password_enabled,
	input  wire logic       can_id_saved,
	input  wire logic       power_good_flag,
	input  wire logic [6:0] error_inputs,
	input  wire logic       signal_present_a,
	input  wire logic [6:0] headroom_a,
	output logic            power_on_out,
	output logic            fault_out,
	output logic            show_standby,
	output logic            show_unlock,
	output logic            show_password,
	output logic            show_reset_screen,
	output logic            keep_can_id,
	output logic            wipe_config
);
	// Two-flop synchronisers for every used pin input except remote_mode
	logic [8:0] pin_s1_reg;
	logic [8:0] pin_s2_reg;
	logic [8:0] pins_raw;
	assign pins_raw = {ctrl_voltage_ok_a, ctrl_voltage_ok_b, bridge_power_ok, encoder_pressed,
		mute_power_button, password_enabled, can_id_saved, power_good_flag,
		signal_present_a};
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= pins_raw;
			pin_s2_reg <= pin_s1_reg;
		end
	end
	logic volt_a, volt_b, bridge_ok, enc_s, btn_s, pwd_s, saved_s, pgood_s, isp_s, any_err;
	assign volt_a  = pin_s2_reg[8];
	assign volt_b  = pin_s2_reg[7];
	assign bridge_ok = pin_s2_reg[6];
	assign enc_s   = pin_s2_reg[5];
	assign btn_s   = pin_s2_reg[4];
	assign pwd_s   = pin_s2_reg[3];
	assign saved_s = pin_s2_reg[2];
	assign pgood_s = pin_s2_reg[1];
	assign isp_s   = pin_s2_reg[0];
	logic [6:0] err_s1_reg, err_s2_reg, hr_s1_reg, hr_s2_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			err_s1_reg <= '0;
			err_s2_reg <= '0;
			hr_s1_reg  <= '0;
			hr_s2_reg  <= '0;
		end else begin
			err_s1_reg <= error_inputs;
			err_s2_reg <= err_s1_reg;
			hr_s1_reg  <= headroom_a;
			hr_s2_reg  <= hr_s1_reg;
		end
	end
	// Only first-channel flags count; raw pins are never combined before the flops
	assign any_err = |(err_s2_reg & ERR_MASK);

	function automatic logic [6:0] robank_clamp(input logic [6:0] v, input logic [6:0] lim);
		robank_clamp = (v > lim) ? lim : v;
	endfunction : robank_clamp

	// Power-up sequencing state
	robank_state_t state_reg, state_next;
	logic          first_reg;
	logic          keep_reg, keep_next;
	always_comb begin
		state_next = state_reg;
		keep_next  = keep_reg;
		case (state_reg)
			ROBANK_BOOT: begin
				// Sample the button once synchroniser has settled
				if (first_reg) begin
					state_next = btn_s ? ROBANK_RESET : ROBANK_RUN;
				end
			end
			ROBANK_RUN: state_next = ROBANK_RUN;
			ROBANK_RESET: begin
				keep_next = saved_s;
				if (!btn_s)
					state_next = ROBANK_HALT;
			end
			ROBANK_HALT: state_next = ROBANK_HALT;
			default: state_next = ROBANK_BOOT;
		endcase
	end
	logic [1:0] boot_cnt_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg    <= ROBANK_BOOT;
			first_reg    <= 1'b0;
			keep_reg     <= 1'b0;
			boot_cnt_reg <= 2'h0;
		end else begin
			state_reg    <= state_next;
			keep_reg     <= keep_next;
			boot_cnt_reg <= (boot_cnt_reg == 2'h3) ? boot_cnt_reg : boot_cnt_reg + 2'h1;
			first_reg    <= (boot_cnt_reg == 2'h2);
		end
	end
	logic running;
	assign running = (state_reg == ROBANK_RUN);

	// Object storage, first channel and common only
	logic [6:0] pwr_cmd_reg, pwr_cmd_next;
	logic       lock_req_reg, lock_req_next;
	logic       lock_act_reg, lock_act_next;
	logic [6:0] dual_reg, dual_next;
	logic [6:0] att_reg, att_next;
	logic [6:0] chsw_reg, chsw_next;
	logic [6:0] crs_reg, crs_next;
	logic [6:0] fine_reg, fine_next;
	logic [6:0] pilot_reg, pilot_next;
	logic [6:0] ind_reg, ind_next;
	logic [31:0] hold_cnt_reg, hold_cnt_next;
	logic       wr_ok;
	assign wr_ok = obj_wr && running;
	always_comb begin
		pwr_cmd_next  = pwr_cmd_reg;
		lock_req_next = lock_req_reg;
		lock_act_next = lock_act_reg;
		dual_next     = dual_reg;
		att_next      = att_reg;
		chsw_next     = chsw_reg;
		crs_next      = crs_reg;
		fine_next     = fine_reg;
		pilot_next    = pilot_reg;
		ind_next      = ind_reg;
		hold_cnt_next = '0;
		// Unlock is decided first so a lock write in the same cycle wins
		if (lock_act_reg && enc_s) begin
			hold_cnt_next = hold_cnt_reg + 32'h1;
			if (hold_cnt_reg >= 32'(UNLOCK_CYCLES - 1)) begin
				lock_act_next  = 1'b0;
				lock_req_next  = 1'b0;
				hold_cnt_next  = '0;
			end
		end
		if (wr_ok) begin
			case (obj_addr)
				OFS_STATUS: begin
					pwr_cmd_next  = {6'h00, obj_wdata[ST_POWER_ON]};
					lock_req_next = obj_wdata[ST_LOCK_CMD];
				end
				OFS_DUAL_SW:      dual_next  = obj_wdata;
				OFS_ATTEN_A:      att_next   = obj_wdata;
				OFS_CHAN_A_SW:    chsw_next  = obj_wdata & CHAN_SW_MASK;
				OFS_DLY_COARSE_A: crs_next   = robank_clamp(obj_wdata, COARSE_MAX);
				OFS_DLY_FINE_A:   fine_next  = robank_clamp(obj_wdata, FINE_MAX);
				OFS_OUT_PILOT:    pilot_next = obj_wdata & PILOT_WR_MASK;
				OFS_IND_A:        ind_next   = obj_wdata & IND_MASK;
				default: ;
			endcase
		end
		// Lock sets on any status write with the lock bit set; writing it clear does not unlock
		if (wr_ok && obj_addr == OFS_STATUS && obj_wdata[ST_LOCK_CMD])
			lock_act_next = 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pwr_cmd_reg  <= OBJ_RESET;
			lock_req_reg <= 1'b0;
			lock_act_reg <= 1'b0;
			dual_reg     <= OBJ_RESET;
			att_reg      <= ATTEN_RESET;
			chsw_reg     <= OBJ_RESET;
			crs_reg      <= OBJ_RESET;
			fine_reg     <= OBJ_RESET;
			pilot_reg    <= OBJ_RESET;
			ind_reg      <= OBJ_RESET;
			hold_cnt_reg <= '0;
		end else begin
			pwr_cmd_reg  <= pwr_cmd_next;
			lock_req_reg <= lock_req_next;
			lock_act_reg <= lock_act_next;
			dual_reg     <= dual_next;
			att_reg      <= att_next;
			chsw_reg     <= chsw_next;
			crs_reg      <= crs_next;
			fine_reg     <= fine_next;
			pilot_reg    <= pilot_next;
			ind_reg      <= ind_next;
			hold_cnt_reg <= hold_cnt_next;
		end
	end

	// Power decision per remote mode; connectors paralleled so either carries voltage
	logic volt_any, on_next;
	assign volt_any = volt_a | volt_b;
	always_comb begin
		on_next = 1'b0;
		case (remote_mode)
			MODE_SIMPLE:    on_next = volt_any;
			MODE_SWITCHING: on_next = bridge_ok && pwr_cmd_reg[0];
			MODE_FULL:      on_next = pwr_cmd_reg[0];
			default:        on_next = 1'b0;
		endcase
		if (!running)
			on_next = 1'b0;
	end

	logic [6:0] status_rd, rdata_next;
	assign status_rd = {1'b0, any_err, remote_mode != MODE_SIMPLE, lock_req_reg,
		lock_act_reg, pgood_s, power_on_out};
	always_comb begin
		rdata_next = obj_rdata;
		if (obj_rd) begin
			case (obj_addr)
				OFS_STATUS:       rdata_next = status_rd;
				OFS_DUAL_SW:      rdata_next = dual_reg;
				OFS_ATTEN_A:      rdata_next = att_reg;
				OFS_CHAN_A_SW:    rdata_next = chsw_reg;
				OFS_DLY_COARSE_A: rdata_next = crs_reg;
				OFS_DLY_FINE_A:   rdata_next = fine_reg;
				OFS_ERRORS:       rdata_next = err_s2_reg & ERR_MASK;
				OFS_OUT_PILOT:    rdata_next = {6'h00, isp_s} & PILOT_RD_MASK;
				OFS_IND_A:        rdata_next = ind_reg;
				OFS_HEADROOM_A:   rdata_next = hr_s2_reg;
				default:          rdata_next = 7'h00;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			obj_rdata         <= 7'h00;
			power_on_out      <= 1'b0;
			fault_out         <= 1'b0;
			show_standby      <= 1'b0;
			show_unlock       <= 1'b0;
			show_password     <= 1'b0;
			show_reset_screen <= 1'b0;
			keep_can_id       <= 1'b0;
			wipe_config       <= 1'b0;
		end else begin
			obj_rdata         <= rdata_next;
			power_on_out      <= on_next;
			fault_out         <= any_err && remote_mode == MODE_SIMPLE;
			show_standby      <= running && !on_next;
			show_unlock       <= lock_act_reg;
			show_password     <= pwd_s;
			show_reset_screen <= (state_reg == ROBANK_HALT);
			keep_can_id       <= keep_reg;
			wipe_config       <= (state_reg == ROBANK_RESET);
		end
	end

	a_unlock_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(lock_act_reg) |-> $past(hold_cnt_reg) == 32'(UNLOCK_CYCLES - 1))
		else $error("unlock without full hold");
	a_coarse_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		crs_reg <= COARSE_MAX)
		else $error("coarse delay above limit");
	a_halt_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_reg == ROBANK_HALT |=> ##1 !power_on_out)
		else $error("powered after factory reset");
	a_fault_simple: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(any_err && remote_mode == MODE_SIMPLE) |=> fault_out)
		else $error("fault output missed");
	a_bridge_loss: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!bridge_ok && remote_mode == MODE_SWITCHING) |=> !power_on_out)
		else $error("on despite bridge loss");
	a_full_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && remote_mode == MODE_FULL && pwr_cmd_reg[0]) |=> power_on_out)
		else $error("full mode dropped power");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(chsw_reg & ~CHAN_SW_MASK) == 7'h00)
		else $error("reserved bit stored");
	a_chan_b_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(obj_rd && obj_addr == OFS_ATTEN_B) |=> obj_rdata == 7'h00)
		else $error("second channel answered");
	a_simple_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && remote_mode == MODE_SIMPLE && volt_any) |=> power_on_out)
		else $error("voltage did not switch on");
	a_lock_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_ok && obj_addr == OFS_STATUS && obj_wdata[ST_LOCK_CMD]) |=> lock_act_reg)
		else $error("lock command ignored");
endmodule : robank_top
`default_nettype wire

/* tb/robank_bridge_model.sv */
// Purpose: Bridge-side model that reads and writes remote objects
// Assumes: One object per strobe, strobes one cycle long
// Notes:   Signals are set by blocking assignment at time zero, then change only by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module robank_bridge_model (
	input  wire logic       clk_sys,
	output logic            obj_wr,
	output logic            obj_rd,
	output logic      [3:0] obj_addr,
	output logic      [6:0] obj_wdata,
	input  wire logic [6:0] obj_rdata
);
	initial begin
		obj_wr = 1'b0;
		obj_rd = 1'b0;
		obj_addr = 4'h0;
		obj_wdata = 7'h00;
	end

	// Codes go out as given; range limits are the device's job
	task automatic put(input logic [3:0] a, input logic [6:0] d);
		@(posedge clk_sys);
		obj_wr <= 1'b1;
		obj_addr <= a;
		obj_wdata <= d;
		@(posedge clk_sys);
		obj_wr <= 1'b0;
		// Stale data is not left on the lines after the strobe
		obj_wdata <= ~d;
	endtask : put

	task automatic get(input logic [3:0] a, output logic [6:0] d);
		@(posedge clk_sys);
		obj_rd <= 1'b1;
		obj_addr <= a;
		@(posedge clk_sys);
		obj_rd <= 1'b0;
		@(posedge clk_sys);
		d = obj_rdata;
	endtask : get
endmodule : robank_bridge_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the remote object register bank
// Assumes: 125 MHz clock, reset held four cycles
// Notes:   Two-second unlock hold is too long to run; only its prompt is seen
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import robank_pkg::*;
	logic       clk_sys, rst_n, obj_wr, obj_rd, enc, btn, pwd, saved, pgood, sig_a;
	logic       volt_a, volt_b, bridge_ok;
	logic [3:0] obj_addr;
	logic [6:0] obj_wdata, obj_rdata, errs, hroom;
	logic [1:0] mode;
	logic       pwr, fault, stby, unlk, pwdsh, rscr, keep_id, wipe;
	int         num_errors = 0;
	int         check_count = 0;

	robank_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_addr(obj_addr), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
		.run_start(1'b0), .remote_mode(mode), .ctrl_voltage_ok_a(volt_a),
		.ctrl_voltage_ok_b(volt_b), .bridge_power_ok(bridge_ok), .encoder_pressed(enc),
		.mute_power_button(btn), .password_enabled(pwd), .can_id_saved(saved),
		.power_good_flag(pgood), .error_inputs(errs), .signal_present_a(sig_a),
		.headroom_a(hroom), .power_on_out(pwr), .fault_out(fault), .show_standby(stby),
		.show_unlock(unlk), .show_password(pwdsh), .show_reset_screen(rscr),
		.keep_can_id(keep_id), .wipe_config(wipe));
	robank_bridge_model bus (.clk_sys(clk_sys), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_addr(obj_addr), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [3:0] a, input logic [6:0] e);
		logic [6:0] v;
		bus.get(a, v);
		chk(v, e);
	endtask : rd

	task automatic wrd(input logic [3:0] a, input logic [6:0] d, input logic [6:0] e);
		bus.put(a, d);
		rd(a, e);
	endtask : wrd

	task automatic do_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask : do_reset

	task automatic t_objects();
		wrd(OFS_ATTEN_A, 7'h7F, 7'h7F);
		wrd(OFS_DUAL_SW, 7'h7F, 7'h7F);
		wrd(OFS_CHAN_A_SW, 7'h7F, CHAN_SW_MASK);
		wrd(OFS_DLY_COARSE_A, 7'h17, COARSE_MAX);
		wrd(OFS_DLY_COARSE_A, 7'h16, 7'h16);
		wrd(OFS_DLY_FINE_A, FINE_MAX, 7'h7F);
		wrd(OFS_IND_A, 7'h7F, IND_MASK);
		wrd(OFS_ATTEN_B, 7'h2A, 7'h00);
		wrd(OFS_CHAN_B_SW, 7'h7F, 7'h00);
		wrd(OFS_DLY_COARSE_B, 7'h05, 7'h00);
		wrd(OFS_DLY_FINE_B, 7'h05, 7'h00);
		wrd(OFS_IND_B, 7'h7F, 7'h00);
		wrd(OFS_HEADROOM_B, 7'h7F, 7'h00);
		wrd(OFS_HEADROOM_A, 7'h00, 7'h55);
		wrd(OFS_ERRORS, 7'h00, ERR_MASK);
		wrd(OFS_OUT_PILOT, 7'h7E, PILOT_RD_MASK);
		rd(OFS_STATUS, 7'h22);
	endtask : t_objects

	task automatic t_simple();
		volt_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({6'h00, pwr}, 7'h01);
		volt_b <= 1'b0;
		volt_a <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({5'h00, stby, pwr}, 7'h01);
		volt_a <= 1'b0;
		errs <= 7'h01;
		repeat (5) @(posedge clk_sys);
		chk({4'h0, fault, stby, pwr}, 7'h06);
		errs <= 7'h00;
		pwd <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({5'h00, fault, pwdsh}, 7'h01);
	endtask : t_simple

	task automatic t_bridge();
		mode <= MODE_FULL;
		bridge_ok <= 1'b1;
		wrd(OFS_STATUS, 7'h7F, 7'h1F);
		chk({5'h00, unlk, pwr}, 7'h03);
		enc <= 1'b1;
		repeat (20) @(posedge clk_sys);
		enc <= 1'b0;
		bridge_ok <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk({5'h00, unlk, pwr}, 7'h03);
		mode <= MODE_SWITCHING;
		repeat (5) @(posedge clk_sys);
		chk({6'h00, pwr}, 7'h00);
		bridge_ok <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({6'h00, pwr}, 7'h01);
	endtask : t_bridge

	task automatic t_factory();
		btn <= 1'b1;
		do_reset();
		chk({5'h00, keep_id, wipe}, 7'h03);
		btn <= 1'b0;
		volt_a <= 1'b1;
		mode <= MODE_SIMPLE;
		repeat (8) @(posedge clk_sys);
		chk({5'h00, rscr, pwr}, 7'h02);
		wrd(OFS_ATTEN_A, 7'h11, 7'h00);
	endtask : t_factory

	initial begin
		rst_n = 1'b0;
		{enc, btn, pwd, volt_a, volt_b, bridge_ok, sig_a} = 7'h00;
		saved = 1'b1;
		pgood = 1'b1;
		mode = MODE_SIMPLE;
		errs = 7'h00;
		hroom = 7'h55;
		do_reset();
		errs <= 7'h7F;
		sig_a <= 1'b1;
		t_objects();
		errs <= 7'h00;
		t_simple();
		pwd <= 1'b0;
		t_bridge();
		t_factory();
		report_and_stop();
	end

	// The whole run takes under two hundred cycles
	initial begin
		#100us;
		num_errors++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
